// ===== logic/uiem_irq_mask.sv
// Interrupt enable mask, disable companion and request logic of a USB
// host controller function. Assumes one register access per cycle on
// the host bus clock and one-cycle event pulses from the controller core.
`timescale 1ns/100ps
`default_nettype none
module uiem_irq_mask
    import uiem_pkg::*;
#(
    // Set to 0 where the management interrupt pin is not fitted
    parameter bit MGMT_PRESENT = 1'b1
) (
    // Clock and resets
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              SW_RESET,
    // Register port
    input  wire uiem_req_t         REG_REQ,
    output logic      [REG_W-1:0]  REG_RDATA,
    output logic                   REG_RVALID,
    // Controller events
    input  wire uiem_evt_t         EVENTS,
    // Interrupt requests
    output logic                   HOST_IRQ,
    output logic                   SYSTEM_MGMT_IRQ_N
);

    logic [REG_W-1:0] enable_r;
    logic [REG_W-1:0] enable_nxt;
    logic [REG_W-1:0] status_flags;
    logic [REG_W-1:0] evt_vec;
    logic [REG_W-1:0] wmask;
    logic [REG_W-1:0] pending;
    logic [REG_W-1:0] rdata_nxt;
    logic             wr_status;
    logic             wr_enable;
    logic             wr_disable;
    logic             irq_nxt;
    logic             mgmt_nxt;
    logic             host_irq_r;
    logic             mgmt_n_r;
    logic [REG_W-1:0] rdata_r;
    logic             rvalid_r;

    // Address decode
    assign wr_status  = REG_REQ.wr && (REG_REQ.addr == STATUS_OFS);
    assign wr_enable  = REG_REQ.wr && (REG_REQ.addr == ENABLE_OFS);
    assign wr_disable = REG_REQ.wr && (REG_REQ.addr == DISABLE_OFS);

    // Reserved positions are stripped before an enable or disable write takes effect
    assign wmask = REG_REQ.wdata & ENABLE_IMPL;

    // Event pulses placed at the status bit positions
    always_comb begin
        evt_vec = STATUS_RESET;
        // Without the management pin the ownership flag stays at zero
        evt_vec[OWN_CHG_BIT]   = EVENTS.ownership_change & MGMT_PRESENT;
        evt_vec[RPC_BIT]       = EVENTS.root_port_change;
        evt_vec[FCO_BIT]       = EVENTS.frame_count_overflow;
        evt_vec[UNREC_BIT]     = EVENTS.unrecoverable_error;
        evt_vec[RD_BIT]        = EVENTS.resume_detected;
        evt_vec[FRM_START_BIT] = EVENTS.frame_start;
        evt_vec[DQW_BIT] = EVENTS.done_queue_written;
        evt_vec[SO_BIT]  = EVENTS.sched_overrun;
    end

    uiem_status_flags #(
        .WIDTH (REG_W),
        .IMPL  (STATUS_IMPL)
    ) u_status (
        .clk      (CLK),
        .reset_n  (RESET_N),
        .sw_reset (SW_RESET),
        .set_vec  (evt_vec),
        .clr_vec  (wr_status ? REG_REQ.wdata : STATUS_RESET),
        .flags_r  (status_flags)
    );

    // Enable register: set-only at its own offset, clear-only through the
    // companion, so software never needs a read-modify-write
    always_comb begin
        enable_nxt = enable_r;
        if (wr_enable) begin
            enable_nxt = enable_r | wmask;
        end else if (wr_disable) begin
            enable_nxt = enable_r & ~wmask;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            enable_r <= ENABLE_RESET;
        end else if (SW_RESET) begin
            enable_r <= ENABLE_RESET;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // Per-event gating, each enable paired with the same status position
    assign pending = status_flags & enable_r;

    always_comb begin
        irq_nxt  = 1'b0;
        mgmt_nxt = 1'b0;
        if (enable_r[MASTER_EN_BIT]) begin
            irq_nxt  = |(pending & HOST_IRQ_SRC);
            mgmt_nxt = pending[OWN_CHG_BIT] & MGMT_PRESENT;
        end
    end

    // Individual sources, listed so each position is traceable
    logic src_own;
    logic src_rpc;
    logic src_fco;
    logic src_unrec;
    logic src_rd;
    logic src_frm;
    logic src_dqw;
    logic src_so;
    assign src_own   = pending[OWN_CHG_BIT];
    assign src_rpc   = pending[RPC_BIT];
    assign src_fco   = pending[FCO_BIT];
    assign src_unrec = pending[UNREC_BIT];
    assign src_rd    = pending[RD_BIT];
    assign src_frm   = pending[FRM_START_BIT];
    assign src_dqw = pending[DQW_BIT];
    assign src_so  = pending[SO_BIT];

    // Registered requests keep glitches off the interrupt lines
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            host_irq_r <= 1'b0;
            mgmt_n_r   <= 1'b1;
        end else begin
            host_irq_r <= irq_nxt;
            mgmt_n_r   <= !mgmt_nxt;
        end
    end

    // Read data: the companion returns the enable register
    always_comb begin
        case (REG_REQ.addr)
            STATUS_OFS:  rdata_nxt = status_flags;
            ENABLE_OFS:  rdata_nxt = enable_r;
            DISABLE_OFS: rdata_nxt = enable_r;
            default:     rdata_nxt = STATUS_RESET;
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r  <= STATUS_RESET;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= REG_REQ.rd;
            if (REG_REQ.rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign REG_RDATA         = rdata_r;
    assign REG_RVALID        = rvalid_r;
    assign HOST_IRQ          = host_irq_r;
    assign SYSTEM_MGMT_IRQ_N = mgmt_n_r;

    // Checks

    property p_enable_pairing;
        @(posedge CLK) disable iff (!RESET_N)
        enable_r[MASTER_EN_BIT] && !src_rpc && !src_fco && !src_unrec
            && !src_rd && !src_frm && !src_dqw && !src_so
        |=> !HOST_IRQ;
    endproperty
    a_enable_pairing: assert property (p_enable_pairing)
        else $error("interrupt raised by a masked or idle event");

    property p_irq_raise;
        @(posedge CLK) disable iff (!RESET_N)
        enable_r[MASTER_EN_BIT] && (src_rpc || src_fco || src_unrec
            || src_rd || src_frm || src_dqw || src_so)
        |=> HOST_IRQ;
    endproperty
    a_irq_raise: assert property (p_irq_raise)
        else $error("enabled pending event did not raise interrupt");

    property p_set_only;
        @(posedge CLK) disable iff (!RESET_N)
        wr_enable && !SW_RESET
        |=> enable_r == ($past(enable_r) | ($past(REG_REQ.wdata)
            & ENABLE_IMPL));
    endproperty
    a_set_only: assert property (p_set_only)
        else $error("enable write did not act as set-only");

    property p_read_value;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.rd && !REG_REQ.wr && !SW_RESET
            && (REG_REQ.addr == ENABLE_OFS)
        |=> REG_RVALID && (REG_RDATA == enable_r)
            && $stable(enable_r);
    endproperty
    a_read_value: assert property (p_read_value)
        else $error("enable read returned wrong value or changed it");

    property p_master_off;
        @(posedge CLK) disable iff (!RESET_N)
        !enable_r[MASTER_EN_BIT] |=> !HOST_IRQ && SYSTEM_MGMT_IRQ_N;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("interrupt raised with master enable clear");

    property p_clear_only;
        @(posedge CLK) disable iff (!RESET_N)
        wr_disable && !SW_RESET
        |=> enable_r == ($past(enable_r) & ~($past(REG_REQ.wdata)
            & ENABLE_IMPL));
    endproperty
    a_clear_only: assert property (p_clear_only)
        else $error("disable write did not act as clear-only");

    property p_disable_read;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.rd && (REG_REQ.addr == DISABLE_OFS)
        |=> REG_RDATA == $past(enable_r);
    endproperty
    a_disable_read: assert property (p_disable_read)
        else $error("disable read did not return enable value");

    property p_mgmt_route;
        @(posedge CLK) disable iff (!RESET_N)
        enable_r[MASTER_EN_BIT] && src_own && !src_rpc && !src_fco
            && !src_unrec && !src_rd && !src_frm && !src_dqw && !src_so
        |=> !SYSTEM_MGMT_IRQ_N && !HOST_IRQ;
    endproperty
    a_mgmt_route: assert property (p_mgmt_route)
        else $error("ownership change not routed to management line");

    property p_own_enable;
        @(posedge CLK) disable iff (!RESET_N)
        !enable_r[OWN_CHG_BIT] |=> SYSTEM_MGMT_IRQ_N;
    endproperty
    a_own_enable: assert property (p_own_enable)
        else $error("management interrupt with ownership enable clear");

    property p_soft_reset;
        @(posedge CLK) disable iff (!RESET_N)
        SW_RESET |=> (enable_r == ENABLE_RESET) ##1 !HOST_IRQ;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("reset did not clear the enable mask");

    property p_reserved_zero;
        @(posedge CLK) disable iff (!RESET_N)
        REG_RVALID |-> REG_RDATA[RSV_HI:RSV_LO] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits read as nonzero");

    property p_rvalid_once;
        @(posedge CLK) disable iff (!RESET_N)
        REG_RVALID |-> $past(REG_REQ.rd);
    endproperty
    a_rvalid_once: assert property (p_rvalid_once)
        else $error("read valid without a read strobe");

    property p_status_read;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.rd && (REG_REQ.addr == STATUS_OFS)
        |=> REG_RDATA == $past(status_flags);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read did not return the flags");

    property p_unmapped_read;
        @(posedge CLK) disable iff (!RESET_N)
        REG_REQ.rd && (REG_REQ.addr != STATUS_OFS)
            && (REG_REQ.addr != ENABLE_OFS)
            && (REG_REQ.addr != DISABLE_OFS)
        |=> REG_RDATA == '0;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read returned nonzero data");

    // A reserved enable bit would still gate nothing, but reads would lie
    property p_reserved_enable;
        @(posedge CLK) disable iff (!RESET_N)
        enable_r[RSV_HI:RSV_LO] == '0;
    endproperty
    a_reserved_enable: assert property (p_reserved_enable)
        else $error("reserved enable bit became set");

endmodule
`default_nettype wire

// ===== logic/uiem_pkg.sv
// Shared constants and carrier types for the host-controller interrupt
// enable mask. Assumes a 32-bit register port on the host bus clock.
package uiem_pkg;

    // Register geometry
    localparam int          REG_W         = 32;
    localparam int          ADDR_W        = 8;

    // Register offsets from the function's base address
    localparam logic [7:0]  STATUS_OFS    = 8'h0C;
    localparam logic [7:0]  ENABLE_OFS    = 8'h10;
    localparam logic [7:0]  DISABLE_OFS   = 8'h14;

    // Field positions, shared by status and enable registers except the enable-only master bit
    localparam int          MASTER_EN_BIT = 31;
    localparam int          OWN_CHG_BIT   = 30;
    localparam int          RPC_BIT       = 6;
    localparam int          FCO_BIT       = 5;
    localparam int          UNREC_BIT     = 4;
    localparam int          RD_BIT        = 3;
    localparam int          FRM_START_BIT = 2;
    localparam int          DQW_BIT       = 1;
    localparam int          SO_BIT        = 0;
    localparam int          RSV_HI        = 29;
    localparam int          RSV_LO        = 7;

    // Reset values
    localparam logic [31:0] ENABLE_RESET  = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;

    // Implemented bits; everything else reads zero and ignores writes
    localparam logic [31:0] ENABLE_IMPL   = 32'hC000_007F;
    localparam logic [31:0] STATUS_IMPL   = 32'h4000_007F;
    // Events that go to the ordinary host-bus interrupt
    localparam logic [31:0] HOST_IRQ_SRC  = 32'h0000_007F;

    // One register access per cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr;
        logic              rd;
        logic [REG_W-1:0]  wdata;
    } uiem_req_t;

    // One-cycle event pulses from the controller core
    typedef struct packed {
        logic ownership_change;
        logic root_port_change;
        logic frame_count_overflow;
        logic unrecoverable_error;
        logic resume_detected;
        logic frame_start;
        logic done_queue_written;
        logic sched_overrun;
    } uiem_evt_t;

endpackage

// ===== logic/uiem_status_flags.sv
// Sticky event-status flags: hardware sets, software clears by writing 1.
// Assumes set and clear vectors are already aligned to bit positions.
`timescale 1ns/100ps
`default_nettype none
module uiem_status_flags
    import uiem_pkg::*;
#(
    parameter int          WIDTH = REG_W,
    parameter logic [31:0] IMPL  = STATUS_IMPL
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             sw_reset,
    // Set and clear requests
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic [WIDTH-1:0] clr_vec,
    // Flags
    output logic      [WIDTH-1:0] flags_r
);

    if (WIDTH != REG_W) begin : g_chk
        $error("uiem_status_flags: WIDTH must equal the register width");
    end

    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        if (IMPL[i]) begin : g_impl
            // A set in the same cycle as a clear wins, so no event is lost
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    flags_r[i] <= STATUS_RESET[i];
                end else if (sw_reset) begin
                    flags_r[i] <= STATUS_RESET[i];
                end else if (set_vec[i]) begin
                    flags_r[i] <= 1'b1;
                end else if (clr_vec[i]) begin
                    flags_r[i] <= 1'b0;
                end
            end

            property p_set_wins;
                @(posedge clk) disable iff (!reset_n)
                set_vec[i] && !sw_reset |=> flags_r[i];
            endproperty
            a_set_wins: assert property (p_set_wins)
                else $error("status flag not set by its event");

            property p_clear_one;
                @(posedge clk) disable iff (!reset_n)
                clr_vec[i] && !set_vec[i] |=> !flags_r[i];
            endproperty
            a_clear_one: assert property (p_clear_one)
                else $error("status flag survived a write of one");
        end else begin : g_rsv
            assign flags_r[i] = 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== test/uiem_host_model.sv
// Host software model: register accesses on the strobe port.
// Assumes registered read data one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module uiem_host_model
    import uiem_pkg::*;
(
    // Clock
    input  wire logic             clk,
    // Register port
    output var uiem_req_t         req,
    input  wire logic [REG_W-1:0] rdata,
    input  wire logic             rvalid
);
    initial req = '0;

    // Strobes move on falling edges so each spans exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk);
        req.addr  = a;
        req.wdata = d;
        req.wr    = 1'b1;
        @(negedge clk);
        req.wr    = 1'b0;
        // Stale data would hide a design that samples the bus late
        req.wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk);
        req.addr = a;
        req.rd   = 1'b1;
        @(negedge clk);
        d        = (rvalid === 1'b1) ? rdata : 'x;
        req.rd   = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/tb_usb_host_irq_enable_mask.sv
// Self-checking bench for the interrupt enable mask.
// Assumes the host model drives all register traffic.
`timescale 1ns/100ps
`default_nettype none
module tb_usb_host_irq_enable_mask;
    import uiem_pkg::*;
    // Whole run needs well under a thousand cycles
    localparam int LIMIT = 5000;
    logic             CLK;
    logic             RESET_N;
    logic             SW_RESET;
    uiem_req_t        req;
    uiem_evt_t        EVENTS;
    logic [REG_W-1:0] rdata;
    logic             rvalid;
    logic             host_irq;
    logic             mgmt_n;
    logic [REG_W-1:0] rdata_b;
    logic             rvalid_b;
    logic             host_irq_b;
    logic             mgmt_n_b;
    int               err_total = 0;
    int               n_tests = 0;
    int               cycles = 0;

    uiem_irq_mask i_dut (
        .CLK               (CLK),
        .RESET_N           (RESET_N),
        .SW_RESET          (SW_RESET),
        .REG_REQ           (req),
        .REG_RDATA         (rdata),
        .REG_RVALID        (rvalid),
        .EVENTS            (EVENTS),
        .HOST_IRQ          (host_irq),
        .SYSTEM_MGMT_IRQ_N (mgmt_n)
    );

    // Same block without the management pin: ownership events must vanish
    uiem_irq_mask #(
        .MGMT_PRESENT (1'b0)
    ) i_dut_bare (
        .CLK               (CLK),
        .RESET_N           (RESET_N),
        .SW_RESET          (SW_RESET),
        .REG_REQ           (req),
        .REG_RDATA         (rdata_b),
        .REG_RVALID        (rvalid_b),
        .EVENTS            (EVENTS),
        .HOST_IRQ          (host_irq_b),
        .SYSTEM_MGMT_IRQ_N (mgmt_n_b)
    );

    uiem_host_model i_host (
        .clk    (CLK),
        .req    (req),
        .rdata  (rdata),
        .rvalid (rvalid)
    );

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        i_host.rd(a, d);
        check($sformatf("reg %h", a), d, exp);
    endtask

    task automatic check_irq(input logic host, input logic mgmt);
        check("host_irq", {31'h0, host_irq}, {31'h0, host});
        check("mgmt_irq_n", {31'h0, mgmt_n}, {31'h0, mgmt});
        // Without the management pin only the host line may ever move
        check("bare host_irq", {31'h0, host_irq_b}, {31'h0, host});
        check("bare mgmt_irq_n", {31'h0, mgmt_n_b}, 32'h0000_0001);
    endtask

    // Event sampled at the first rising edge, interrupt at the next rising edge
    task automatic pulse(input logic [7:0] e);
        @(negedge CLK);
        EVENTS = uiem_evt_t'(e);
        @(negedge CLK);
        EVENTS = '0;
        @(negedge CLK);
    endtask

    task automatic t_reset();
        check_irq(1'b0, 1'b1);
        check_reg(ENABLE_OFS, 32'h0000_0000);
        check_reg(DISABLE_OFS, 32'h0000_0000);
        check_reg(STATUS_OFS, 32'h0000_0000);
    endtask

    task automatic t_w1s();
        i_host.wr(ENABLE_OFS, 32'h0000_0005);
        i_host.wr(ENABLE_OFS, 32'h0000_0002);
        check_reg(ENABLE_OFS, 32'h0000_0007);
        check_reg(ENABLE_OFS, 32'h0000_0007);
        i_host.wr(ENABLE_OFS, 32'h3FFF_FF80);
        check_reg(ENABLE_OFS, 32'h0000_0007);
        check_reg(DISABLE_OFS, 32'h0000_0007);
        i_host.wr(DISABLE_OFS, 32'h0000_0002);
        check_reg(ENABLE_OFS, 32'h0000_0005);
        check_reg(8'h20, 32'h0000_0000);
        i_host.wr(DISABLE_OFS, 32'hFFFF_FFFF);
        check_reg(ENABLE_OFS, 32'h0000_0000);
    endtask

    // Each host-line event against a neighbour's enable, then its own
    task automatic t_bits();
        logic [31:0] own;
        logic [31:0] other;
        for (int i = 0; i < 7; i++) begin
            own   = 32'h1 << i;
            other = 32'h1 << ((i + 1) % 7);
            i_host.wr(ENABLE_OFS, other | 32'h8000_0000);
            pulse(own[7:0]);
            check_irq(1'b0, 1'b1);
            check_reg(STATUS_OFS, own);
            i_host.wr(ENABLE_OFS, own);
            @(negedge CLK);
            check_irq(1'b1, 1'b1);
            i_host.wr(STATUS_OFS, 32'h0000_0000);
            @(negedge CLK);
            check_irq(1'b1, 1'b1);
            i_host.wr(STATUS_OFS, own);
            @(negedge CLK);
            check_irq(1'b0, 1'b1);
            i_host.wr(DISABLE_OFS, 32'hFFFF_FFFF);
        end
    endtask

    task automatic t_master();
        i_host.wr(ENABLE_OFS, 32'h0000_0004);
        pulse(8'h04);
        check_irq(1'b0, 1'b1);
        i_host.wr(ENABLE_OFS, 32'h8000_0000);
        @(negedge CLK);
        check_irq(1'b1, 1'b1);
        i_host.wr(DISABLE_OFS, 32'h8000_0000);
        @(negedge CLK);
        check_irq(1'b0, 1'b1);
        i_host.wr(STATUS_OFS, 32'h0000_0004);
        i_host.wr(DISABLE_OFS, 32'hFFFF_FFFF);
    endtask

    // Ownership pending first with its own enable clear, then unmasked
    task automatic t_owner();
        i_host.wr(ENABLE_OFS, 32'h8000_0000);
        pulse(8'h80);
        check_irq(1'b0, 1'b1);
        i_host.wr(ENABLE_OFS, 32'h4000_0000);
        @(negedge CLK);
        check_irq(1'b0, 1'b0);
        check_reg(STATUS_OFS, 32'h4000_0000);
        check("bare rvalid", {31'h0, rvalid_b}, 32'h0000_0001);
        check("bare status", rdata_b, 32'h0000_0000);
        i_host.wr(STATUS_OFS, 32'h4000_0000);
        @(negedge CLK);
        check_irq(1'b0, 1'b1);
    endtask

    task automatic t_swreset();
        i_host.wr(ENABLE_OFS, 32'hFFFF_FFFF);
        check_reg(ENABLE_OFS, ENABLE_IMPL);
        pulse(8'h01);
        check_irq(1'b1, 1'b1);
        @(negedge CLK);
        SW_RESET = 1'b1;
        @(negedge CLK);
        SW_RESET = 1'b0;
        check_reg(ENABLE_OFS, 32'h0000_0000);
        check_reg(STATUS_OFS, 32'h0000_0000);
        check_irq(1'b0, 1'b1);
    endtask

    // A mid-run reset must clear the mask, the flags and both lines
    task automatic t_hwreset();
        i_host.wr(ENABLE_OFS, 32'h8000_0004);
        pulse(8'h04);
        check_irq(1'b1, 1'b1);
        RESET_N = 1'b0;
        @(negedge CLK);
        check_irq(1'b0, 1'b1);
        RESET_N = 1'b1;
        check_reg(ENABLE_OFS, 32'h0000_0000);
        check_reg(STATUS_OFS, 32'h0000_0000);
    endtask

    initial begin
        RESET_N  = 1'b0;
        SW_RESET = 1'b0;
        EVENTS   = '0;
        repeat (5) @(negedge CLK);
        RESET_N = 1'b1;
        t_reset();
        t_w1s();
        t_bits();
        t_master();
        t_owner();
        t_swreset();
        t_hwreset();
        conclude();
    end
endmodule
`default_nettype wire
